// [rtl/pss_map.vh]
// register offsets, field positions, commit codes and timing counts
// assumes inclusion by the status/commit register bank only, the store does not include it
`ifndef PSS_MAP_VH
`define PSS_MAP_VH
// ************************************************************
// register offsets
// ************************************************************
`define PSS_ADDR_TEMP 8'h79
`define PSS_ADDR_PROX_HI 8'h7a
`define PSS_ADDR_PROX_LO 8'h7b
`define PSS_ADDR_STATUS 8'h7e
`define PSS_ADDR_COMMIT 8'h7f
`define PSS_ADDR_LAST_MAIN 8'h72
`define PSS_ADDR_LAST_ALL 8'h78
`define PSS_ADDR_TABLE_END 8'h5d
`define PSS_ADDR_INIT_START 8'h66
`define PSS_ADDR_FINAL_START 8'h73
// ************************************************************
// status field positions
// ************************************************************
`define PSS_ST_TIMEOUT 7
`define PSS_ST_STORE_ERR 6
`define PSS_ST_IDLE 5
`define PSS_ST_COMMIT 4
// ************************************************************
// commit codes and lock states
// ************************************************************
`define PSS_CODE_MAIN 8'h08
`define PSS_CODE_FINAL 8'h10
`define PSS_CODE_ALL 8'h20
`define PSS_CODE_READONLY 8'h40
`define PSS_CODE_DISABLE 8'h80
`define PSS_LOCK_NONE 4'h0
`define PSS_LOCK_MAIN 4'h1
`define PSS_LOCK_ALL 4'h3
`define PSS_LOCK_READONLY 4'h7
`define PSS_LOCK_DISABLED 4'hf
// ************************************************************
// temperature and timing
// ************************************************************
`define PSS_TEMP_OFFSET 8'h40
`define PSS_NV_WORD_NS 1000
`define PSS_CLK_NS 40
`define PSS_NV_WORD_CYC ((`PSS_NV_WORD_NS + `PSS_CLK_NS - 1) / `PSS_CLK_NS)
`endif

// [rtl/pss_nv_store.v]
// nonvolatile image of the register space, one byte per address
// assumes one write or one read per cycle, read data registered
module pss_nv_store #(
  parameter AW = 7,
  parameter DW = 8
) (
  input wire i_clk_sys,          // system clock
  input wire i_we,               // write strobe
  input wire [AW-1:0] i_addr,    // address
  input wire [DW-1:0] i_wdata,   // write data
  output reg [DW-1:0] o_rdata    // registered read data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // write, with the registered read returning the byte held before that write
  always @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule

// [rtl/pss_status_regs.v]
// status, proximity snapshot, temperature and commit request registers
// assumes link decoder in the same clock domain gives one-cycle strobes;
// reply goes out by sinking current on the indicator light pin
`include "pss_map.vh"

// Notes on behaviour
// R1 - temperature byte reads as degrees Celsius plus sixty-four
// R2 - reading proximity high byte snapshots converter result into both bytes
// R3 - proximity low byte changes only at a high-byte read snapshot
// R4 - host should read high then low byte as a pair
// R5 - status bit 7 converter timeout, bit 6 storage error, set on event
// R6 - status bit 5 reads zero while busy, one when idle
// R7 - status bit 4 is one while a commit runs
// R8 - lock field 0x0, 0x1, 0x3 for nothing, main, all committed
// R9 - lock field 0x7 read-only link, 0xf disabled link
// R10 - status read returns a single byte, no auto-increment
// R11 - code 0x08 stores 0x00-0x5d and 0x66-0x72
// R12 - code 0x10 stores final registers 0x73-0x78
// R13 - code 0x20 stores every register 0x00-0x78
// R14 - code 0x40 makes link read-only, 0x80 disables it
// R15 - host derives tank resistance from proximity over two to fifteen
// R16 - replies sink current on indicator pin, not driving link line
// R17 - accepted code raises commit flag, lock updates when commit ends
// R18 - writes ignored while link is read-only or disabled
module pss_status_regs #(
  parameter NV_WORD_CYC = `PSS_NV_WORD_CYC
) (
  input wire i_clk_sys,            // 25 mhz system clock
  input wire i_rstn,               // async reset, active low
  input wire i_rd,                 // link read strobe, one cycle
  input wire i_wr,                 // link write strobe, one cycle
  input wire [7:0] i_addr,         // link register address
  input wire [7:0] i_wdata,        // link write data
  input wire i_rd_next,            // host asks for following byte
  input wire [15:0] i_prox_result, // converter result, same clock
  input wire [7:0] i_temp_c,       // signed celsius, same clock
  input wire i_conv_timeout,       // converter timeout pulse
  input wire i_store_err,          // storage error pulse
  input wire i_core_busy,          // conversion busy level
  input wire [7:0] i_cfg_rdata,    // byte of other register space
  output reg [7:0] o_rdata,        // read byte
  output reg o_rvalid,             // read byte valid, one cycle
  output reg o_reply_end,          // no further bytes follow
  output wire o_led_sink_n,        // indicator pin sink, low sinks
  output wire o_led_oe_n,          // indicator pin enable, low drives
  output wire o_wr_accept,         // write passed on to register space
  output wire o_link_off,          // link disabled
  output reg [3:0] o_lock_state,   // link lock state
  output wire [6:0] o_nv_addr,     // address being committed
  output wire o_nv_busy            // commit walking the space
);
  // ************************************************************
  // commit state machine
  // ************************************************************
  localparam ST_IDLE = 2'b00;
  localparam ST_WALK = 2'b01;
  localparam ST_DONE = 2'b10;

  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [7:0] code_q;
  reg [6:0] ptr_q;
  reg [15:0] cnt_q;
  reg [15:0] prox_q;
  reg timeout_q;
  reg err_q;
  reg [7:0] rd_addr_q;
  reg reply_q;
  wire locked;
  wire code_ok;
  wire wr_commit;
  wire [6:0] first_addr;
  wire [6:0] last_addr;
  wire word_done;
  wire [7:0] nv_rdata;
  wire skip;
  // 8-bit copies of the address constants, sliced to 7 bits for the walk pointer
  wire [7:0] final_start_w;
  wire [7:0] last_main_w;
  wire [7:0] last_all_w;

  assign final_start_w = `PSS_ADDR_FINAL_START;
  assign last_main_w = `PSS_ADDR_LAST_MAIN;
  assign last_all_w = `PSS_ADDR_LAST_ALL;

  // decode accepted commit codes
  function is_code;
    input [7:0] c;
    begin
      is_code = (c == `PSS_CODE_MAIN) || (c == `PSS_CODE_FINAL) ||
                (c == `PSS_CODE_ALL) || (c == `PSS_CODE_READONLY) ||
                (c == `PSS_CODE_DISABLE);
    end
  endfunction

  // R18 write lockout
  assign locked = (o_lock_state == `PSS_LOCK_READONLY) ||
                  (o_lock_state == `PSS_LOCK_DISABLED);
  assign o_link_off = (o_lock_state == `PSS_LOCK_DISABLED);
  assign code_ok = is_code(i_wdata);
  assign wr_commit = i_wr && !locked && (st_q == ST_IDLE) &&
                     (i_addr == `PSS_ADDR_COMMIT) && code_ok;
  assign o_wr_accept = i_wr && !locked && (i_addr < `PSS_ADDR_TEMP);

  // R11 R12 R13 address span per code
  assign first_addr = (code_q == `PSS_CODE_FINAL) ?
                      final_start_w[6:0] : 7'h00;
  assign last_addr = (code_q == `PSS_CODE_MAIN) ?
                     last_main_w[6:0] : last_all_w[6:0];
  // R11 gap skipped
  assign skip = (code_q == `PSS_CODE_MAIN) &&
                (ptr_q > `PSS_ADDR_TABLE_END) &&
                (ptr_q < `PSS_ADDR_INIT_START);
  assign word_done = (cnt_q == NV_WORD_CYC - 1) || skip;
  assign o_nv_busy = (st_q == ST_WALK) && !skip;
  assign o_nv_addr = ptr_q;

  // next commit state
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (wr_commit) begin
          st_d = ST_WALK;
        end
      end
      ST_WALK: begin
        // R14 link modes need no store walk
        if (code_q == `PSS_CODE_READONLY || code_q == `PSS_CODE_DISABLE) begin
          st_d = ST_DONE;
        end else if (word_done && ptr_q == last_addr) begin
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // R17 commit sequencing and lock update
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= ST_IDLE;
      code_q <= 8'h00;
      ptr_q <= 7'h00;
      cnt_q <= 16'h0000;
      o_lock_state <= `PSS_LOCK_NONE;
    end else begin
      st_q <= st_d;
      if (wr_commit) begin
        code_q <= i_wdata;
        ptr_q <= (i_wdata == `PSS_CODE_FINAL) ?
                 final_start_w[6:0] : 7'h00;
        cnt_q <= 16'h0000;
      end else if (st_q == ST_WALK) begin
        if (word_done) begin
          cnt_q <= 16'h0000;
          ptr_q <= ptr_q + 7'h01;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
      if (st_q == ST_DONE) begin
        // R8 R9 R14 lock state after commit
        case (code_q)
          `PSS_CODE_MAIN: begin
            if (o_lock_state == `PSS_LOCK_NONE) begin
              o_lock_state <= `PSS_LOCK_MAIN;
            end
          end
          `PSS_CODE_FINAL: begin
            if (o_lock_state == `PSS_LOCK_MAIN) begin
              o_lock_state <= `PSS_LOCK_ALL;
            end
          end
          `PSS_CODE_ALL: begin
            o_lock_state <= `PSS_LOCK_ALL;
          end
          `PSS_CODE_READONLY: begin
            o_lock_state <= `PSS_LOCK_READONLY;
          end
          `PSS_CODE_DISABLE: begin
            o_lock_state <= `PSS_LOCK_DISABLED;
          end
          default: begin
            o_lock_state <= o_lock_state;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // nonvolatile image
  // ************************************************************
  // image stores register bytes as the walk passes each address outside the skipped gap
  pss_nv_store #(
    .AW(7),
    .DW(8)
  ) u_store (
    .i_clk_sys(i_clk_sys),
    .i_we(o_nv_busy && word_done),
    .i_addr(ptr_q),
    .i_wdata(i_cfg_rdata),
    .o_rdata(nv_rdata)
  );

  // ************************************************************
  // status flags and snapshot
  // ************************************************************
  // R5 sticky flags, event wins over status read clear
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      timeout_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      if (i_conv_timeout) begin
        timeout_q <= 1'b1;
      end else if (i_rd && i_addr == `PSS_ADDR_STATUS) begin
        timeout_q <= 1'b0;
      end
      if (i_store_err) begin
        err_q <= 1'b1;
      end else if (i_rd && i_addr == `PSS_ADDR_STATUS) begin
        err_q <= 1'b0;
      end
    end
  end

  // R2 R3 snapshot on high-byte read only
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      prox_q <= 16'h0000;
    end else if (i_rd && i_addr == `PSS_ADDR_PROX_HI) begin
      prox_q <= i_prox_result;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  // read data mux, status byte flags sampled before the clear
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
      o_reply_end <= 1'b0;
      rd_addr_q <= 8'h00;
    end else begin
      o_rvalid <= i_rd && !o_link_off;
      rd_addr_q <= i_addr;
      // R10 status read ends the reply
      o_reply_end <= i_rd && (i_addr == `PSS_ADDR_STATUS || !i_rd_next);
      if (i_rd) begin
        case (i_addr)
          // R1 offset temperature
          `PSS_ADDR_TEMP: o_rdata <= i_temp_c + `PSS_TEMP_OFFSET;
          // R2 high byte straight from the converter
          `PSS_ADDR_PROX_HI: o_rdata <= i_prox_result[15:8];
          // R3 low byte from the snapshot
          `PSS_ADDR_PROX_LO: o_rdata <= prox_q[7:0];
          // R5 R6 R7 R8 status byte
          `PSS_ADDR_STATUS: begin
            o_rdata <= {timeout_q, err_q,
                        !(i_core_busy || st_q != ST_IDLE),
                        st_q != ST_IDLE, o_lock_state};
          end
          `PSS_ADDR_COMMIT: o_rdata <= 8'h00;
          default: o_rdata <= i_cfg_rdata;
        endcase
      end
    end
  end

  // R16 reply by sinking indicator current while bits go out
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      reply_q <= 1'b0;
    end else begin
      reply_q <= i_rd && !o_link_off;
    end
  end
  assign o_led_oe_n = !reply_q;
  assign o_led_sink_n = 1'b0;
endmodule

// [verification/pss_status_regs_properties.sv]
// checker for the status and commit register bank
// assumes it is bound to pss_status_regs, one clock domain
module pss_props (
  input wire i_clk_sys,
  input wire i_rstn,
  input wire i_rd,
  input wire i_wr,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire [15:0] i_prox_result,
  input wire [7:0] i_temp_c,
  input wire o_led_sink_n,
  input wire o_led_oe_n,
  input wire o_rvalid,
  input wire o_reply_end,
  input wire [7:0] o_rdata,
  input wire o_wr_accept,
  input wire [3:0] o_lock_state,
  input wire o_nv_busy
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  logic [7:0] snap_q;
  wire rd_ok = i_rd && o_lock_state != 4'hf;
  wire [7:0] prox_hi = i_prox_result[15:8];
  wire cm_free = i_wr && i_addr == 8'h7f && !o_nv_busy && !o_lock_state[2];
  // low byte as it should stand after each high byte read
  always @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn)
      snap_q <= 8'h00;
    else if (rd_ok && i_addr == 8'h7a)
      snap_q <= i_prox_result[7:0];
  end
  chk_read_answer: assert property (rd_ok |=> o_rvalid)
    else $error("read gave no byte");
  chk_status_single: assert property (rd_ok && i_addr == 8'h7e |=> o_reply_end)
    else $error("status read not closed");
  chk_temp_offset: assert property (rd_ok && i_addr == 8'h79 |=>
    o_rdata == $past(i_temp_c) + 8'h40)
    else $error("temperature byte wrong");
  chk_prox_high: assert property (rd_ok && i_addr == 8'h7a |=>
    o_rdata == $past(prox_hi))
    else $error("high byte wrong");
  chk_low_held: assert property (rd_ok && i_addr == 8'h7b |=>
    o_rdata == $past(snap_q))
    else $error("low byte not from snapshot");
  chk_busy_bits: assert property (rd_ok && i_addr == 8'h7e && o_nv_busy |=>
    o_rdata[5:4] == 2'b01)
    else $error("busy bits wrong in commit");
  chk_commit_start: assert property (cm_free && i_wdata == 8'h20 &&
    !$past(o_nv_busy) |=> o_nv_busy)
    else $error("commit did not start");
  chk_disable_lock: assert property (cm_free && i_wdata == 8'h80 &&
    !$past(o_nv_busy) |-> ##3 o_lock_state == 4'hf)
    else $error("link not disabled");
  chk_lock_write: assert property (o_lock_state[2] |-> !o_wr_accept)
    else $error("write passed while locked");
  chk_led_reply: assert property (o_rvalid |-> !o_led_oe_n && !o_led_sink_n)
    else $error("reply not sunk on indicator");
  cover property (rd_ok && i_addr == 8'h7e);
  cover property (o_lock_state == 4'h3);
  cover property (o_lock_state == 4'hf);
endmodule
bind pss_status_regs pss_props u_props (.i_clk_sys, .i_rstn, .i_rd, .i_wr,
  .i_addr, .i_wdata, .i_prox_result, .i_temp_c, .o_led_sink_n, .o_led_oe_n,
  .o_rvalid, .o_reply_end, .o_rdata, .o_wr_accept, .o_lock_state, .o_nv_busy);

// [verification/pss_host_model.sv]
// host side of the single-wire configuration link
// assumes the bank samples one-cycle strobes on the rising edge
module pss_host_model (
  input wire i_clk,          // system clock
  input wire [7:0] i_rdata,  // read byte
  input wire i_rvalid,       // read byte valid
  output logic o_rd,         // read strobe
  output logic o_wr,         // write strobe
  output logic [7:0] o_addr, // address
  output logic [7:0] o_wdata // write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // one strobe cycle, then released lines scrambled
  task xfer(input logic w, input logic [7:0] a, d,
            output logic [7:0] q, output logic ok);
    @(posedge i_clk);
    o_rd <= !w;
    o_wr <= w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    #1;
    q = i_rdata;
    ok = i_rvalid;
  endtask
  // high byte first, then low byte
  task read_pair(output logic [15:0] v);
    logic g;
    xfer(1'b0, 8'h7a, 8'h00, v[15:8], g);
    xfer(1'b0, 8'h7b, 8'h00, v[7:0], g);
  endtask
endmodule

// [verification/testbench.sv]
// self-checking bench for the status and commit register bank
// assumes a 25 mhz clock and a two-cycle commit word time
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] a, t, e; logic [15:0] p;} pss_row_t;
  logic i_clk_sys, i_rstn, i_rd_next, i_conv_timeout, i_store_err;
  logic i_core_busy, ok;
  logic [15:0] i_prox_result;
  logic [7:0] i_temp_c, i_cfg_rdata, q;
  wire i_rd, i_wr, o_rvalid, o_reply_end, o_led_sink_n, o_led_oe_n;
  wire o_wr_accept, o_link_off, o_nv_busy;
  wire [7:0] i_addr, i_wdata, o_rdata;
  wire [3:0] o_lock_state;
  wire [6:0] o_nv_addr;
  int bad_count, total_checks;
  pss_row_t rows[8] = '{'{8'h79, 8'h00, 8'h40, 16'h1234},
    '{8'h79, 8'hd8, 8'h18, 16'h1234}, '{8'h79, 8'h3f, 8'h7f, 16'h1234},
    '{8'h7a, 8'h3f, 8'h12, 16'h1234}, '{8'h7b, 8'h3f, 8'h34, 16'h5678},
    '{8'h7b, 8'h3f, 8'h34, 16'h9abc}, '{8'h7a, 8'h3f, 8'h9a, 16'h9abc},
    '{8'h7b, 8'h3f, 8'hbc, 16'h9abc}};
  pss_status_regs #(.NV_WORD_CYC(2)) DUT (.*);
  pss_host_model host (.i_clk(i_clk_sys), .i_rdata(o_rdata),
    .i_rvalid(o_rvalid), .o_rd(i_rd), .o_wr(i_wr), .o_addr(i_addr),
    .o_wdata(i_wdata));
  // ****
  // shared tasks
  // ****
  task chk(input logic [7:0] e, s, input string n);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task rd8(input logic [7:0] a);
    host.xfer(1'b0, a, 8'h00, q, ok);
  endtask
  // write a code, follow the walk, then check the lock
  task commit(input logic [7:0] c, input logic [6:0] lo, hi,
              input logic [3:0] l, input bit mid);
    logic [6:0] mn, mx;
    int n;
    mn = 7'h7f;
    mx = 7'h00;
    n = 0;
    host.xfer(1'b1, 8'h7f, c, q, ok);
    if (mid) begin
      rd8(8'h7e);
      chk(8'h13, o_rdata, "walk status");
    end
    do begin
      @(posedge i_clk_sys);
      #1;
      n++;
      if (o_nv_busy && o_nv_addr < mn) mn = o_nv_addr;
      if (o_nv_busy && o_nv_addr > mx) mx = o_nv_addr;
    end while ((o_nv_busy || n < 2 || (c == 8'h08 && o_nv_addr > 7'h5d &&
               o_nv_addr < 7'h66)) && n < 600);
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk({4'h0, l}, {4'h0, o_lock_state}, "lock");
    if (c < 8'h40) chk({1'b0, hi}, {1'b0, mx}, "last addr");
    if (c == 8'h10) chk({1'b0, lo}, {1'b0, mn}, "first addr");
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  // watchdog well past the expected run
  initial begin
    #200000;
    bad_count++;
    stop_test;
  end
  // ****
  // main sequence
  // ****
  initial begin
    {i_rstn, i_rd_next, i_conv_timeout, i_store_err, i_core_busy} = 5'h00;
    i_prox_result = 16'h0000;
    i_temp_c = 8'h00;
    i_cfg_rdata = 8'h5a;
    repeat (3) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    #1;
    chk({4'h0, o_lock_state, 3'h0, o_led_oe_n}, 8'h01, "reset");
    foreach (rows[i]) begin
      @(posedge i_clk_sys);
      i_temp_c <= rows[i].t;
      i_prox_result <= rows[i].p;
      rd8(rows[i].a);
      chk(rows[i].e, o_rdata, "row");
    end
    @(posedge i_clk_sys);
    {i_conv_timeout, i_store_err} <= 2'b11;
    @(posedge i_clk_sys);
    {i_conv_timeout, i_store_err, i_core_busy} <= 3'b001;
    i_rd_next <= 1'b1;
    rd8(8'h7e);
    chk(8'hc0, o_rdata, "flags busy");
    chk(8'h01, {7'h00, o_reply_end}, "single byte");
    rd8(8'h79);
    chk(8'h00, {7'h00, o_reply_end}, "continued byte");
    @(posedge i_clk_sys);
    i_core_busy <= 1'b0;
    i_rd_next <= 1'b0;
    rd8(8'h7e);
    chk(8'h20, o_rdata, "flags cleared");
    commit(8'h08, 7'h00, 7'h72, 4'h1, 1'b0);
    commit(8'h10, 7'h73, 7'h78, 4'h3, 1'b0);
    commit(8'h20, 7'h00, 7'h78, 4'h3, 1'b1);
    commit(8'h40, 7'h00, 7'h00, 4'h7, 1'b0);
    host.xfer(1'b1, 8'h10, 8'h33, q, ok);
    commit(8'h80, 7'h00, 7'h00, 4'h7, 1'b0);
    rd8(8'h7e);
    chk(8'h27, o_rdata, "read only");
    @(posedge i_clk_sys);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    commit(8'h80, 7'h00, 7'h00, 4'hf, 1'b0);
    rd8(8'h7e);
    chk(8'h00, {7'h00, ok}, "disabled read");
    stop_test;
  end
endmodule
